// File: hdl/dlgo_defs.svh
`ifndef DLGO_DEFS_SVH
`define DLGO_DEFS_SVH

// Register offsets on the register access port
`define DLGO_OFS_LOAD_MODE 4'h7
`define DLGO_OFS_OUT_SEL 4'h8
`define DLGO_OFS_OUT_LVL 4'h9

// Field positions and widths
`define DLGO_MODE_MSB 1
`define DLGO_PIN_MSB 7
`define DLGO_DAC_MSB 11
`define DLGO_REG_MSB 15
`define DLGO_ADDR_MSB 3
`define DLGO_CH_MSB 2

// Load-mode codes
`define DLGO_MODE_DIRECT 2'h0
`define DLGO_MODE_HOLD 2'h1
`define DLGO_MODE_BATCH 2'h2
`define DLGO_MODE_UNDEF 2'h3

// Reset values
`define DLGO_RST_LOAD_MODE 2'h0
`define DLGO_RST_PIN 8'h00
`define DLGO_RST_DAC 12'h000

`endif

// File: hdl/dlgo_pkg.sv
`default_nettype none
package dlgo_pkg;

  // Batch transfer sequencer, Gray along idle, copy, update
  typedef enum logic [1:0] {
    DLGO_IDLE = 2'h0,
    DLGO_COPY = 2'h1,
    DLGO_UPDT = 2'h3
  } dlgo_fsm_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [1:0] load_mode;
    logic [7:0] out_sel;
    logic [7:0] out_lvl;
    logic [7:0] pin_drv;
    logic [7:0][11:0] dac_in;
    logic [7:0][11:0] dac_reg;
    logic [7:0] dac_upd;
    logic [15:0] rdata;
    logic rvalid;
    dlgo_fsm_t fsm;
  } dlgo_state_t;

endpackage

`default_nettype wire

// File: hdl/dlgo_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlgo_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - Two-bit load mode field, resets to zero
// R2 - Code 00: input write goes straight out
// R3 - Code 01: inputs held, outputs unchanged
// R4 - Code 10: copy all, then update together
// R5 - Load mode bits 15:2 read zero
// R6 - Select bit n makes pin n output
// R7 - Clear select bit leaves pin untouched
// R8 - Selected pin follows its level bit
// R9 - Eight bits read/write, upper byte zero
// R10 - Select and level reset to zero
// R11 - Host avoids code 11; acts as 00
// R12 - Level reaches pin only while selected
module dlgo_regs (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [`DLGO_ADDR_MSB:0] reg_addr, // Register offset
  input wire logic [`DLGO_REG_MSB:0] reg_wdata, // Register write data
  output logic [`DLGO_REG_MSB:0] reg_rdata, // Registered read data
  output logic reg_rvalid, // Read data valid pulse
  input wire logic dac_in_wr, // DAC input register write strobe
  input wire logic [`DLGO_CH_MSB:0] dac_in_ch, // DAC channel written
  input wire logic [`DLGO_DAC_MSB:0] dac_in_data, // DAC input data
  output logic [7:0][11:0] dac_code, // DAC register contents
  output logic [`DLGO_PIN_MSB:0] dac_update, // Per-channel analog update pulse
  output logic [`DLGO_PIN_MSB:0] gpio_out, // Pin output level
  output logic [`DLGO_PIN_MSB:0] gpio_oe // Pin output enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and decode

  dlgo_pkg::dlgo_state_t st_r; // Registered state
  dlgo_pkg::dlgo_state_t st_nxt; // Next state
  logic wr_mode; // Write to load mode register
  logic wr_sel; // Write to select register
  logic wr_lvl; // Write to level register
  logic direct_mode; // Input writes pass straight through
  logic [`DLGO_PIN_MSB:0] drv_nxt; // Next pin drive levels

  // Address decode; a write to any other offset is dropped
  assign wr_mode = reg_wr_en && (reg_addr == `DLGO_OFS_LOAD_MODE);
  assign wr_sel = reg_wr_en && (reg_addr == `DLGO_OFS_OUT_SEL);
  assign wr_lvl = reg_wr_en && (reg_addr == `DLGO_OFS_OUT_LVL);
  // Undefined code falls back to direct loading
  assign direct_mode = (st_r.load_mode == `DLGO_MODE_DIRECT) ||
                       (st_r.load_mode == `DLGO_MODE_UNDEF); // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin drive: a level change reaches the pin only while selected

  genvar gi;
  generate
    for (gi = 0; gi <= `DLGO_PIN_MSB; gi++) begin : g_pin
      // Selected pin takes its level bit, otherwise keeps its last drive
      assign drv_nxt[gi] = st_r.out_sel[gi] ? st_r.out_lvl[gi] : st_r.pin_drv[gi]; // [R8] [R12]

      // Selected pin shows the level held one cycle earlier
      AST_PIN_FOLLOW: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!arst_n)
        st_r.out_sel[gi] |=> gpio_out[gi] == $past(st_r.out_lvl[gi]))
        else $error("Selected pin not following its level bit");

      // Unselected pin keeps its drive whatever the level register does
      AST_PIN_HOLD: assert property ( // [R12]
        @(posedge sys_clk) disable iff (!arst_n)
        !st_r.out_sel[gi] |=> $stable(gpio_out[gi]))
        else $error("Unselected pin lost its drive level");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    // Everything holds unless a branch below moves it
    st_nxt = st_r;
    // Update pulses and read valid last a single cycle
    st_nxt.dac_upd = `DLGO_RST_PIN;
    st_nxt.rvalid = 1'b0;
    // Pin drive comes from the per-pin loop
    st_nxt.pin_drv = drv_nxt;
    // Software writes; only documented bits are stored
    if (wr_mode) begin
      st_nxt.load_mode = reg_wdata[`DLGO_MODE_MSB:0]; // [R1]
    end
    if (wr_sel) begin
      st_nxt.out_sel = reg_wdata[`DLGO_PIN_MSB:0]; // [R6] [R9]
    end
    if (wr_lvl) begin
      st_nxt.out_lvl = reg_wdata[`DLGO_PIN_MSB:0]; // [R9]
    end
    // Reads; unmapped offsets and reserved bits return zero
    if (reg_rd_en) begin
      st_nxt.rvalid = 1'b1;
      unique case (reg_addr)
        `DLGO_OFS_LOAD_MODE: st_nxt.rdata = {14'h0, st_r.load_mode}; // [R5]
        `DLGO_OFS_OUT_SEL: st_nxt.rdata = {8'h00, st_r.out_sel}; // [R9]
        `DLGO_OFS_OUT_LVL: st_nxt.rdata = {8'h00, st_r.out_lvl}; // [R9]
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // Input register write; direct mode also loads the DAC register
    if (dac_in_wr) begin
      st_nxt.dac_in[dac_in_ch] = dac_in_data;
      if (direct_mode) begin // [R3] Only direct loading touches the DAC register
        st_nxt.dac_reg[dac_in_ch] = dac_in_data; // [R2]
        st_nxt.dac_upd[dac_in_ch] = 1'b1; // [R2]
      end
      // Hold and batch modes leave DAC registers alone [R3]
    end
    // Batch sequencer: copy all inputs, then update all outputs at once
    unique case (st_r.fsm)
      dlgo_pkg::DLGO_IDLE: begin
        // Only a fresh write of the batch code starts a transfer
        if (wr_mode && (reg_wdata[`DLGO_MODE_MSB:0] == `DLGO_MODE_BATCH)) begin
          st_nxt.fsm = dlgo_pkg::DLGO_COPY; // [R4]
        end
      end
      dlgo_pkg::DLGO_COPY: begin
        // All eight channels copied in one cycle
        st_nxt.dac_reg = st_r.dac_in; // [R4]
        st_nxt.fsm = dlgo_pkg::DLGO_UPDT;
      end
      dlgo_pkg::DLGO_UPDT: begin
        // Every channel updates in the same cycle
        st_nxt.dac_upd = 8'hFF; // [R4]
        st_nxt.fsm = dlgo_pkg::DLGO_IDLE;
      end
      default: begin
        // Unused code returns to idle
        st_nxt.fsm = dlgo_pkg::DLGO_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Mode, pins and converter data all start cleared
      st_r.load_mode <= `DLGO_RST_LOAD_MODE; // [R1]
      st_r.out_sel <= `DLGO_RST_PIN; // [R10]
      st_r.out_lvl <= `DLGO_RST_PIN; // [R10]
      st_r.pin_drv <= `DLGO_RST_PIN;
      st_r.dac_in <= {8{`DLGO_RST_DAC}};
      st_r.dac_reg <= {8{`DLGO_RST_DAC}};
      st_r.dac_upd <= `DLGO_RST_PIN;
      st_r.rdata <= 16'h0000;
      st_r.rvalid <= 1'b0;
      st_r.fsm <= dlgo_pkg::DLGO_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read port
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  // Converter side
  assign dac_code = st_r.dac_reg;
  assign dac_update = st_r.dac_upd;
  // Pin side
  assign gpio_out = st_r.pin_drv;
  // Clear select bit releases the pin to the other configuration logic
  assign gpio_oe = st_r.out_sel; // [R6] [R7]

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Properties below sample registered state one edge after the strobe,
  // so expected values are taken with $past from the strobe cycle, the batch run's from the copy cycle

  // Write of batch code while idle
  sequence s_batch_req;
    wr_mode && (reg_wdata[`DLGO_MODE_MSB:0] == `DLGO_MODE_BATCH) &&
    (st_r.fsm == dlgo_pkg::DLGO_IDLE);
  endsequence

  // Copy then a single all-channel update
  // Outputs carry the inputs as they stood in the copy cycle
  sequence s_batch_run;
    (st_r.fsm == dlgo_pkg::DLGO_COPY) && (dac_update == 8'h00) ##1
    (st_r.fsm == dlgo_pkg::DLGO_UPDT) && (dac_update == 8'h00) ##1
    (dac_update == 8'hFF) && (dac_code == $past(st_r.dac_in, 2));
  endsequence

  // Mode readback: field below, zeros above
  AST_MODE_READ: assert property ( // [R5]
    reg_rd_en && (reg_addr == `DLGO_OFS_LOAD_MODE) |=>
    reg_rvalid && (reg_rdata[15:2] == 14'h0) && (reg_rdata[1:0] == $past(st_r.load_mode)))
    else $error("Load mode readback wrong");

  // Only the two low bits of a mode write are kept
  AST_MODE_WRITE: assert property ( // [R1]
    wr_mode |=> st_r.load_mode == $past(reg_wdata[1:0]))
    else $error("Load mode field not stored");

  // Direct mode: written channel loads and updates next cycle
  AST_DIRECT_LOAD: assert property ( // [R2]
    dac_in_wr && (st_r.load_mode == `DLGO_MODE_DIRECT) && (st_r.fsm == dlgo_pkg::DLGO_IDLE) |=>
    (dac_code[$past(dac_in_ch)] == $past(dac_in_data)) && dac_update[$past(dac_in_ch)])
    else $error("Direct mode did not load the DAC");

  // Hold mode: converter side does not move
  AST_HOLD_NO_LOAD: assert property ( // [R3]
    dac_in_wr && (st_r.load_mode == `DLGO_MODE_HOLD) && (st_r.fsm == dlgo_pkg::DLGO_IDLE) |=>
    $stable(dac_code) && (dac_update == 8'h00))
    else $error("Hold mode changed a DAC output");

  // Batch write runs copy, then update, with no gaps
  AST_BATCH_SEQ: assert property ( // [R4]
    s_batch_req |=> s_batch_run)
    else $error("Batch transfer sequence wrong");

  // Undefined code falls back to direct loading
  AST_UNDEF_AS_DIRECT: assert property ( // [R11]
    dac_in_wr && (st_r.load_mode == `DLGO_MODE_UNDEF) && (st_r.fsm == dlgo_pkg::DLGO_IDLE) |=>
    dac_update[$past(dac_in_ch)] && (dac_code[$past(dac_in_ch)] == $past(dac_in_data)))
    else $error("Undefined code not treated as direct");

  // Enables take the written select byte next cycle
  AST_OE_FOLLOWS_SEL: assert property ( // [R6]
    wr_sel |=> gpio_oe == $past(reg_wdata[7:0]))
    else $error("Output enable does not follow select");

  // Select readback carries a zero upper byte
  AST_SEL_READ: assert property ( // [R9]
    reg_rd_en && (reg_addr == `DLGO_OFS_OUT_SEL) |=>
    reg_rdata == {8'h00, $past(gpio_oe)})
    else $error("Select readback wrong");

  // Level write reaches selected pin zero two cycles on
  AST_PIN_LEVEL: assert property ( // [R8]
    wr_lvl && gpio_oe[0] && (reg_addr == `DLGO_OFS_OUT_LVL) && !wr_sel |=>
    ##1 gpio_out[0] == $past(reg_wdata[0], 2))
    else $error("Selected pin not at its level");

  // Unselected pin zero keeps its drive
  AST_UNSEL_HOLD: assert property ( // [R12]
    !gpio_oe[0] |=> gpio_out[0] == $past(gpio_out[0]))
    else $error("Unselected pin drive changed");

  // Pins come out of reset undriven and low
  AST_RESET_ZERO: assert property ( // [R10]
    $rose(arst_n) |-> (gpio_oe == 8'h00) && (gpio_out == 8'h00))
    else $error("Pin registers not zero after reset");

  // Level register stores the written byte
  AST_LVL_WRITE: assert property ( // [R9]
    wr_lvl |=> st_r.out_lvl == $past(reg_wdata[7:0]))
    else $error("Level register not stored");

  // Level readback carries a zero upper byte
  AST_LVL_READ: assert property ( // [R9]
    reg_rd_en && (reg_addr == `DLGO_OFS_OUT_LVL) |=>
    reg_rvalid && (reg_rdata == {8'h00, $past(st_r.out_lvl)}))
    else $error("Level readback wrong");

  // Read valid is only ever a reply to a strobe
  AST_RVALID_PULSE: assert property ( // [R9]
    !reg_rd_en |=> !reg_rvalid)
    else $error("Read valid without a read strobe");

  // Enables move only on a select write
  AST_SEL_STABLE: assert property ( // [R7]
    !wr_sel |=> $stable(gpio_oe))
    else $error("Output enable changed without a write");

  // Mode field moves only on a mode write
  AST_MODE_KEEP: assert property ( // [R1]
    !wr_mode |=> $stable(st_r.load_mode))
    else $error("Load mode changed without a write");

  // Held writes still land in the input register
  AST_HOLD_KEEPS_INPUT: assert property ( // [R3]
    dac_in_wr && (st_r.load_mode == `DLGO_MODE_HOLD) |=>
    st_r.dac_in[$past(dac_in_ch)] == $past(dac_in_data))
    else $error("Held write lost from the input register");

  // A running transfer is never restarted
  AST_BATCH_NO_RESTART: assert property ( // [R4]
    (st_r.fsm != dlgo_pkg::DLGO_IDLE) |=> (st_r.fsm != dlgo_pkg::DLGO_COPY))
    else $error("Batch transfer restarted while running");

  // Mode and update pulses start cleared
  AST_RESET_MODE: assert property ( // [R1]
    $rose(arst_n) |-> (st_r.load_mode == `DLGO_RST_LOAD_MODE) && (dac_update == 8'h00))
    else $error("Load mode or update not clear after reset");

endmodule // dlgo_regs

`default_nettype wire

// File: testbench/dlgo_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the register port
module dlgo_host (
  input wire logic sys_clk, // System clock
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [3:0] addr, // Offset
  output logic [15:0] wdata, // Write data
  input wire logic [15:0] rdata, // Read data
  input wire logic rvalid // Read valid
);
  // Idle port at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
  end
  // One-cycle write; callers never send load code 11
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
    addr = ~a; // Released lines show inverse
    wdata = ~d;
  endtask
  // One-cycle read, data taken while valid stands
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    addr = ~a;
    d = (rvalid === 1'b1) ? rdata : 16'hXXXX; // Missing valid fails the compare
  endtask
endmodule // dlgo_host
`default_nettype wire

// File: testbench/tb_dac_load_and_gpio_output_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlgo_defs.svh"
module tb_dac_load_and_gpio_output_regs;
  logic sys_clk, arst_n, reg_wr_en, reg_rd_en, reg_rvalid, dac_in_wr;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [2:0] dac_in_ch;
  logic [11:0] dac_in_data;
  logic [7:0][11:0] dac_code;
  logic [7:0] dac_update, gpio_out, gpio_oe, upd_seen;
  int mismatches = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  dlgo_host u_host (.sys_clk(sys_clk), .wr_en(reg_wr_en), .rd_en(reg_rd_en),
    .addr(reg_addr), .wdata(reg_wdata), .rdata(reg_rdata), .rvalid(reg_rvalid));
  dlgo_regs dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_in_wr(dac_in_wr),
    .dac_in_ch(dac_in_ch), .dac_in_data(dac_in_data), .dac_code(dac_code),
    .dac_update(dac_update), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One DAC input write
  task automatic din(input logic [2:0] ch, input logic [11:0] d);
    @(negedge sys_clk);
    dac_in_wr = 1'b1;
    dac_in_ch = ch;
    dac_in_data = d;
    @(negedge sys_clk);
    dac_in_wr = 1'b0;
    dac_in_ch = ~ch;
    dac_in_data = ~d;
  endtask
  // Bounded watch for an update pulse
  task automatic wait_upd(input int n);
    upd_seen = 8'h00;
    for (int i = 0; i < n && upd_seen === 8'h00; i++) begin
      if (i > 0) @(negedge sys_clk);
      upd_seen = dac_update;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped offset
  task automatic t_reset();
    u_host.rd(`DLGO_OFS_LOAD_MODE, rd_val);
    check("mode", rd_val, 16'h0000);
    u_host.rd(`DLGO_OFS_OUT_SEL, rd_val);
    check("sel", rd_val, 16'h0000);
    u_host.rd(`DLGO_OFS_OUT_LVL, rd_val);
    check("lvl", rd_val, 16'h0000);
    u_host.rd(4'hF, rd_val);
    check("unmapped", rd_val, 16'h0000);
    check("pins", {gpio_oe, gpio_out}, 16'h0000);
    $display("t_reset done");
  endtask
  // Select, level, reserved bits, hold while unselected
  task automatic t_gpio();
    u_host.wr(`DLGO_OFS_OUT_SEL, 16'hFF0F);
    u_host.wr(`DLGO_OFS_OUT_LVL, 16'hFFA5);
    u_host.rd(`DLGO_OFS_OUT_SEL, rd_val);
    check("sel", rd_val, 16'h000F);
    u_host.rd(`DLGO_OFS_OUT_LVL, rd_val);
    check("lvl", rd_val, 16'h00A5);
    check("pins", {gpio_oe, gpio_out}, 16'h0F05);
    u_host.wr(`DLGO_OFS_OUT_SEL, 16'h00F0);
    u_host.wr(`DLGO_OFS_OUT_LVL, 16'h0000);
    repeat (2) @(negedge sys_clk);
    check("pins", {gpio_oe, gpio_out}, 16'hF005);
    $display("t_gpio done");
  endtask
  // Direct, hold and batch load modes
  task automatic t_dac();
    din(3'h2, 12'hABC);
    wait_upd(4);
    check("upd", 16'(upd_seen), 16'h0004);
    check("code2", 16'(dac_code[2]), 16'h0ABC);
    @(negedge sys_clk);
    check("upd", 16'(dac_update), 16'h0000);
    u_host.wr(`DLGO_OFS_LOAD_MODE, 16'hFFFD);
    u_host.rd(`DLGO_OFS_LOAD_MODE, rd_val);
    check("mode", rd_val, 16'h0001);
    din(3'h3, 12'h555);
    wait_upd(4);
    check("upd", 16'(upd_seen), 16'h0000);
    check("code3", 16'(dac_code[3]), 16'h0000);
    u_host.wr(`DLGO_OFS_LOAD_MODE, 16'h0002);
    wait_upd(8);
    check("upd", 16'(upd_seen), 16'h00FF);
    check("code3", 16'(dac_code[3]), 16'h0555);
    check("code2", 16'(dac_code[2]), 16'h0ABC);
    @(negedge sys_clk);
    check("upd", 16'(dac_update), 16'h0000);
    $display("t_dac done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0;
    dac_in_wr = 1'b0;
    dac_in_ch = 3'h0;
    dac_in_data = 12'h000;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_gpio();
    t_dac();
    close_out();
  end
endmodule // tb_dac_load_and_gpio_output_regs
`default_nettype wire
